// ===== verilog/gsr_pkg.sv
// Shared constants and types for the general-purpose and segment
// register file of the core.
// Assumes decode supplies mode, operand size and prefix with each access.
`default_nettype none
package gsr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int GPR_W = 64;
  localparam int GPR_COUNT = 16;
  localparam int DWORD_W = 32;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int REG_SEL_W = 4;
  localparam int SEG_COUNT = 6;
  localparam int SEG_IDX_W = 3;
  localparam int SELECTOR_W = 16;
  localparam int LIMIT_W = 32;

  ////////////////////////////////////////////////////////////////////////
  // Selector fields and reset values
  localparam int SEL_INDEX_MSB = 15;
  localparam int SEL_INDEX_LSB = 3;
  localparam logic [12:0] SEL_INDEX_NULL = 13'h0000;
  localparam logic [63:0] GPR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] UPPER_ZERO = 32'h0000_0000;
  localparam logic [15:0] SELECTOR_RESET = 16'h0000;
  localparam logic [31:0] LIMIT_RESET = 32'hFFFF_FFFF;

  ////////////////////////////////////////////////////////////////////////
  // Register numbering: without the extension prefix, byte selectors
  // 4..7 name the high bytes of registers 0..3
  localparam logic [3:0] FIRST_EXT_REG = 4'h8;
  localparam logic [3:0] HIGH_BYTE_FIRST = 4'h4;

  ////////////////////////////////////////////////////////////////////////
  // Segment register indices
  localparam logic [2:0] SEG_EXTRA_DATA = 3'h0;
  localparam logic [2:0] SEG_CODE = 3'h1;
  localparam logic [2:0] SEG_STACK = 3'h2;
  localparam logic [2:0] SEG_DATA = 3'h3;
  localparam logic [2:0] SEG_EXTRA_BASE_F = 3'h4;
  localparam logic [2:0] SEG_EXTRA_BASE_G = 3'h5;

  ////////////////////////////////////////////////////////////////////////
  // Operand size of an access
  typedef enum logic [2:0] {
    OPS_DEFAULT = 3'b000,
    OPS_BYTE = 3'b001,
    OPS_WORD = 3'b010,
    OPS_DWORD = 3'b011,
    OPS_QUAD = 3'b100
  } gsr_opsize_t;

  // Execution mode of the core
  typedef enum logic [1:0] {
    MODE_REAL = 2'b00,
    MODE_LEGACY = 2'b01,
    MODE_COMPAT = 2'b10,
    MODE_LONG = 2'b11
  } gsr_mode_t;

endpackage
`default_nettype wire

// ===== verilog/gsr_write_merge.sv
// Merges a write result into one general-purpose register by width.
// Assumes the size is already resolved (never the default code).
`timescale 1ns/1ps
`default_nettype none
module gsr_write_merge (
  input wire logic [63:0] old_value,
  input wire logic [63:0] wr_value,
  input wire gsr_pkg::gsr_opsize_t wr_size,
  input wire logic high_byte,
  input wire logic wr_hit,
  output logic [63:0] next_value
);

  ////////////////////////////////////////////////////////////////////////
  // Candidate values for each view width
  logic [63:0] merged_byte_low;
  logic [63:0] merged_byte_high;
  logic [63:0] merged_word;
  logic [63:0] merged_dword;
  logic [63:0] merged;

  // Byte and word writes keep all bits above the view
  assign merged_byte_low = {old_value[gsr_pkg::GPR_W-1:gsr_pkg::BYTE_W],
    wr_value[gsr_pkg::BYTE_W-1:0]};
  assign merged_byte_high = {old_value[gsr_pkg::GPR_W-1:gsr_pkg::WORD_W],
    wr_value[gsr_pkg::BYTE_W-1:0],
    old_value[gsr_pkg::BYTE_W-1:0]};
  assign merged_word = {old_value[gsr_pkg::GPR_W-1:gsr_pkg::WORD_W],
    wr_value[gsr_pkg::WORD_W-1:0]};
  // Doubleword writes clear the upper half
  assign merged_dword = {gsr_pkg::UPPER_ZERO,
    wr_value[gsr_pkg::DWORD_W-1:0]};

  // Width selection; quadword replaces the whole register
  assign merged = (wr_size == gsr_pkg::OPS_BYTE) ?
    (high_byte ? merged_byte_high : merged_byte_low) :
    (wr_size == gsr_pkg::OPS_WORD) ? merged_word :
    (wr_size == gsr_pkg::OPS_QUAD) ? wr_value : merged_dword;

  assign next_value = wr_hit ? merged : old_value;

endmodule
`default_nettype wire

// ===== verilog/gsr_regfile.sv
// Sixteen general-purpose registers with width views and six segment
// registers with fetch, stack and data address forming.
// Assumes decode drives mode, size and prefix with every access and that
// all inputs are synchronous to CORE_CLK.
//
// Overview of operation
// - Sixteen registers; default operand width thirty-two bits
// - Byte, word, dword, quad views per register
// - Quad size and registers 8-15 need prefix
// - Registers 8-15 survive compat round trip
// - Legacy round trip clears registers 8-15 to zero
// - Prefix remaps high bytes to pointer lows
// - Never mix high bytes with new bytes
// - Quad write replaces all 64 bits
// - Dword write zeroes upper thirty-two bits
// - Byte and word writes keep upper bits
// - Leaving 64-bit mode drops upper halves of registers 0-7
// - Six segment registers hold 16-bit selectors
// - Fetch address from code segment plus offset
// - Code segment rejects explicit moves
// - Stack ops use stack segment; loads allowed
// - Code, data, extra, stack base zero in 64-bit
// - Two extra-base segments keep base in 64-bit
// - Loads in 64-bit mode still checked
// - No limit checks in 64-bit mode
// - Word alias and low/high byte aliases
`timescale 1ns/1ps
`default_nettype none
module gsr_regfile (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire gsr_pkg::gsr_mode_t MODE_IN,
  input wire logic ACC_VALID,
  input wire gsr_pkg::gsr_opsize_t OP_SIZE,
  input wire logic REGISTER_EXTENSION_PREFIX,
  input wire logic [3:0] RD_A_SEL,
  input wire logic [3:0] RD_B_SEL,
  input wire logic GPR_WR_EN,
  input wire logic [3:0] GPR_WR_SEL,
  input wire logic [63:0] GPR_WR_DATA,
  output logic [63:0] RD_A_DATA,
  output logic [63:0] RD_B_DATA,
  output logic ACCESS_FAULT,
  output logic UPPER_VECTOR_DISCARD,
  input wire logic SEG_LD_EN,
  input wire logic [2:0] SEG_LD_IDX,
  input wire logic SEG_LD_EXPLICIT,
  input wire logic [15:0] SEG_LD_SELECTOR,
  input wire logic [63:0] SEG_LD_BASE,
  input wire logic [31:0] SEG_LD_LIMIT,
  output logic SEG_LD_REJECT,
  input wire logic [2:0] SEG_RD_IDX,
  output logic [15:0] SEG_RD_SELECTOR,
  input wire logic [63:0] INSTRUCTION_OFFSET_POINTER,
  output logic [15:0] FETCH_SELECTOR,
  output logic [63:0] FETCH_LINEAR,
  input wire logic ADDR_VALID,
  input wire logic ADDR_STACK,
  input wire logic [2:0] ADDR_SEG,
  input wire logic [63:0] ADDR_OFFSET,
  output logic [63:0] ADDR_LINEAR,
  output logic ADDR_LIMIT_FAULT
);

  ////////////////////////////////////////////////////////////////////////
  // Selector decode: returns {high_byte, physical register}
  function automatic logic [4:0] map_sel(input logic [3:0] sel,
                                         input logic register_extension_prefix,
                                         input logic is_byte);
    logic high;
    high = is_byte && !register_extension_prefix && (sel >= gsr_pkg::HIGH_BYTE_FIRST) &&
      (sel < gsr_pkg::FIRST_EXT_REG);
    map_sel = high ? {1'b1, 2'b00, sel[1:0]} : {1'b0, sel};
  endfunction

  // Register number needing the prefix
  function automatic logic ext_bad(input logic [3:0] sel,
                                   input logic rex_ok);
    ext_bad = (sel >= gsr_pkg::FIRST_EXT_REG) && !rex_ok;
  endfunction

  // Read view, zero-extended to the full width
  function automatic logic [63:0] view(input logic [63:0] value,
                                       input gsr_pkg::gsr_opsize_t size,
                                       input logic high);
    logic [63:0] res;
    res = value;
    unique case (size)
      gsr_pkg::OPS_BYTE: begin
        res = high ? {56'h00_0000_0000_0000, value[15:8]} :
          {56'h00_0000_0000_0000, value[7:0]};
      end
      gsr_pkg::OPS_WORD: res = {48'h0000_0000_0000, value[15:0]};
      gsr_pkg::OPS_QUAD: res = value;
      default: res = {gsr_pkg::UPPER_ZERO, value[31:0]};
    endcase
    view = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [63:0] gpr [0:15];
  logic [63:0] next_gpr [0:15];
  logic [15:0] seg_sel [0:5];
  logic [63:0] seg_base [0:5];
  logic [31:0] seg_limit [0:5];
  gsr_pkg::gsr_mode_t prev_mode;

  ////////////////////////////////////////////////////////////////////////
  // Access qualification
  logic mode64;
  logic rex_ok;
  logic is_byte;
  gsr_pkg::gsr_opsize_t eff_size;
  logic [4:0] map_a;
  logic [4:0] map_b;
  logic [4:0] map_w;
  logic size_bad;
  logic access_bad;
  logic wr_ok;

  assign mode64 = (MODE_IN == gsr_pkg::MODE_LONG);
  // Prefix only has meaning in 64-bit mode
  assign rex_ok = REGISTER_EXTENSION_PREFIX && mode64;
  // Unsized operations default to doubleword
  assign eff_size = (OP_SIZE == gsr_pkg::OPS_DEFAULT) ?
    gsr_pkg::OPS_DWORD : OP_SIZE;
  assign is_byte = (eff_size == gsr_pkg::OPS_BYTE);
  assign map_a = map_sel(RD_A_SEL, rex_ok, is_byte);
  assign map_b = map_sel(RD_B_SEL, rex_ok, is_byte);
  assign map_w = map_sel(GPR_WR_SEL, rex_ok, is_byte);
  // No quadword view without the prefix
  assign size_bad = (eff_size == gsr_pkg::OPS_QUAD) && !rex_ok;
  assign access_bad = ACC_VALID && (size_bad ||
    ext_bad(RD_A_SEL, rex_ok) || ext_bad(RD_B_SEL, rex_ok) ||
    (GPR_WR_EN && ext_bad(GPR_WR_SEL, rex_ok)));
  assign wr_ok = ACC_VALID && GPR_WR_EN && !access_bad;

  ////////////////////////////////////////////////////////////////////////
  // Mode transition tracking
  logic leave64;
  logic enter_legacy;
  logic to_legacy;

  assign to_legacy = (MODE_IN == gsr_pkg::MODE_REAL) ||
    (MODE_IN == gsr_pkg::MODE_LEGACY);
  // Upper halves of registers 0..7 are dropped on leaving 64-bit mode
  assign leave64 = (prev_mode == gsr_pkg::MODE_LONG) && !mode64;
  // Registers 8..15 are lost only when legacy or real mode is entered
  assign enter_legacy = to_legacy &&
    ((prev_mode == gsr_pkg::MODE_COMPAT) ||
     (prev_mode == gsr_pkg::MODE_LONG));

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      prev_mode <= gsr_pkg::MODE_REAL;
      UPPER_VECTOR_DISCARD <= 1'b0;
    end else begin
      prev_mode <= MODE_IN;
      UPPER_VECTOR_DISCARD <= enter_legacy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-register update: transition clearing, then width merge
  genvar gi;
  generate
    for (gi = 0; gi < gsr_pkg::GPR_COUNT; gi++) begin : g_gpr
      logic [63:0] base_value;
      logic hit;
      if (gi < gsr_pkg::GPR_COUNT / 2) begin : g_legacy
        assign base_value = leave64 ?
          {gsr_pkg::UPPER_ZERO, gpr[gi][31:0]} : gpr[gi];
      end else begin : g_ext
        // Compat mode keeps these untouched
        assign base_value = enter_legacy ?
          gsr_pkg::GPR_RESET : gpr[gi];
      end
      assign hit = wr_ok && (map_w[3:0] == 4'(gi));
      gsr_write_merge u_merge (
        .old_value(base_value),
        .wr_value(GPR_WR_DATA),
        .wr_size(eff_size),
        .high_byte(map_w[4]),
        .wr_hit(hit),
        .next_value(next_gpr[gi])
      );
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
          gpr[gi] <= gsr_pkg::GPR_RESET;
        end else begin
          gpr[gi] <= next_gpr[gi];
        end
      end
    end
  endgenerate

  // Read ports return the view before this cycle's write
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RD_A_DATA <= gsr_pkg::GPR_RESET;
      RD_B_DATA <= gsr_pkg::GPR_RESET;
      ACCESS_FAULT <= 1'b0;
    end else begin
      RD_A_DATA <= view(gpr[map_a[3:0]], eff_size, map_a[4]);
      RD_B_DATA <= view(gpr[map_b[3:0]], eff_size, map_b[4]);
      ACCESS_FAULT <= access_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Segment loads: code only by control transfer, null selector never
  // enters code or stack, checked in every mode
  logic ld_null;
  logic ld_reject;
  logic ld_ok;

  assign ld_null = (SEG_LD_SELECTOR[gsr_pkg::SEL_INDEX_MSB:
    gsr_pkg::SEL_INDEX_LSB] == gsr_pkg::SEL_INDEX_NULL);
  assign ld_reject = SEG_LD_EN && ((SEG_LD_EXPLICIT &&
    (SEG_LD_IDX == gsr_pkg::SEG_CODE)) ||
    (ld_null && ((SEG_LD_IDX == gsr_pkg::SEG_CODE) ||
    (SEG_LD_IDX == gsr_pkg::SEG_STACK))) ||
    (SEG_LD_IDX > gsr_pkg::SEG_EXTRA_BASE_G));
  // Stack segment accepts explicit loads like a data segment, except that a null selector is rejected
  assign ld_ok = SEG_LD_EN && !ld_reject;

  generate
    for (gi = 0; gi < gsr_pkg::SEG_COUNT; gi++) begin : g_seg
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
          seg_sel[gi] <= gsr_pkg::SELECTOR_RESET;
          seg_base[gi] <= gsr_pkg::GPR_RESET;
          seg_limit[gi] <= gsr_pkg::LIMIT_RESET;
        end else if (ld_ok && (SEG_LD_IDX == 3'(gi))) begin
          seg_sel[gi] <= SEG_LD_SELECTOR;
          seg_base[gi] <= SEG_LD_BASE;
          seg_limit[gi] <= SEG_LD_LIMIT;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Address forming
  logic [2:0] use_seg;
  logic base_forced;
  logic [63:0] data_base;
  logic [63:0] code_base;
  logic [63:0] safe_seg_base;
  logic [31:0] safe_seg_limit;
  logic safe_seg;

  // Stack operations always go through the stack segment
  assign use_seg = ADDR_STACK ? gsr_pkg::SEG_STACK : ADDR_SEG;
  assign safe_seg = (use_seg <= gsr_pkg::SEG_EXTRA_BASE_G);
  assign safe_seg_base = safe_seg ? seg_base[use_seg] : gsr_pkg::GPR_RESET;
  assign safe_seg_limit = safe_seg ? seg_limit[use_seg] :
    gsr_pkg::LIMIT_RESET;
  // Only the two extra-base segments keep their base in 64-bit mode
  assign base_forced = mode64 && (use_seg != gsr_pkg::SEG_EXTRA_BASE_F) &&
    (use_seg != gsr_pkg::SEG_EXTRA_BASE_G);
  assign data_base = base_forced ? gsr_pkg::GPR_RESET :
    safe_seg_base;
  assign code_base = mode64 ? gsr_pkg::GPR_RESET :
    seg_base[gsr_pkg::SEG_CODE];

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      SEG_LD_REJECT <= 1'b0;
      SEG_RD_SELECTOR <= gsr_pkg::SELECTOR_RESET;
      FETCH_SELECTOR <= gsr_pkg::SELECTOR_RESET;
      FETCH_LINEAR <= gsr_pkg::GPR_RESET;
      ADDR_LINEAR <= gsr_pkg::GPR_RESET;
      ADDR_LIMIT_FAULT <= 1'b0;
    end else begin
      SEG_LD_REJECT <= ld_reject;
      SEG_RD_SELECTOR <= (SEG_RD_IDX <= gsr_pkg::SEG_EXTRA_BASE_G) ?
        seg_sel[SEG_RD_IDX] : gsr_pkg::SELECTOR_RESET;
      FETCH_SELECTOR <= seg_sel[gsr_pkg::SEG_CODE];
      FETCH_LINEAR <= code_base + INSTRUCTION_OFFSET_POINTER;
      ADDR_LINEAR <= data_base + ADDR_OFFSET;
      // Limits are ignored in 64-bit mode
      ADDR_LIMIT_FAULT <= ADDR_VALID && !mode64 &&
        (ADDR_OFFSET[31:0] > safe_seg_limit);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  quad_needs_prefix_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    ACC_VALID && eff_size == gsr_pkg::OPS_QUAD && !rex_ok
    |=> ACCESS_FAULT && ($past(leave64 || enter_legacy) ||
      gpr[$past(map_w[3:0])] == $past(gpr[map_w[3:0]])))
    else $error("quad access without prefix accepted");

  ext_needs_prefix_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    ACC_VALID && GPR_WR_EN && GPR_WR_SEL[3] && !rex_ok |=> ACCESS_FAULT)
    else $error("extended register used without prefix");

  quad_write_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_ok && eff_size == gsr_pkg::OPS_QUAD
    |=> gpr[$past(map_w[3:0])] == $past(GPR_WR_DATA))
    else $error("quad write did not replace register");

  dword_zero_ext_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_ok && eff_size == gsr_pkg::OPS_DWORD
    |=> gpr[$past(map_w[3:0])] ==
      {gsr_pkg::UPPER_ZERO, $past(GPR_WR_DATA[31:0])})
    else $error("dword write not zero extended");

  word_keep_upper_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    wr_ok && eff_size == gsr_pkg::OPS_WORD && !leave64 && !enter_legacy
    |=> gpr[$past(map_w[3:0])][63:16] ==
      $past(gpr[map_w[3:0]][63:16]))
    else $error("word write changed upper bits");

  no_high_mix_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    ACC_VALID && !access_bad &&
    (map_a[4] || map_b[4] || (GPR_WR_EN && map_w[4]))
    |-> !map_a[3] && !map_b[3] && !(GPR_WR_EN && map_w[3]))
    else $error("high byte mixed with new byte register");

  code_load_reject_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    SEG_LD_EN && SEG_LD_EXPLICIT && SEG_LD_IDX == gsr_pkg::SEG_CODE
    |=> SEG_LD_REJECT ##1 FETCH_SELECTOR == $past(FETCH_SELECTOR))
    else $error("explicit code segment load accepted");

  flat_base_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    mode64 && !ADDR_STACK && ADDR_SEG == gsr_pkg::SEG_DATA
    |=> ADDR_LINEAR == $past(ADDR_OFFSET))
    else $error("data base not zero in 64-bit mode");

  no_limit_64_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    mode64 |=> !ADDR_LIMIT_FAULT)
    else $error("limit fault raised in 64-bit mode");

  ext_keep_compat_a: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    prev_mode == gsr_pkg::MODE_LONG && MODE_IN == gsr_pkg::MODE_COMPAT
    |=> $stable(gpr[gsr_pkg::GPR_COUNT-1]))
    else $error("register 15 lost entering compat mode");

endmodule
`default_nettype wire

// ===== test/gsr_decode_model.sv
// Decode-side partner: presents mode, size, prefix and selectors.
// Assumes the bench calls issue once a cycle at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module gsr_decode_model (
  output var gsr_pkg::gsr_mode_t mode,
  output logic valid,
  output var gsr_pkg::gsr_opsize_t size,
  output logic register_extension_prefix,
  output logic [3:0] sel_a,
  output logic [3:0] sel_b,
  output logic wr_en,
  output logic [3:0] wr_sel,
  output logic [63:0] wr_data
);
  ////////////////////////////////////////////////////////////////////////
  // Idle access in real mode from time zero
  initial begin
    issue(gsr_pkg::MODE_REAL, 1'b0, 1'b0, gsr_pkg::OPS_DEFAULT, 1'b0,
      4'h0, 4'h0, 64'h0);
  end

  // One access; qualifiers always travel with the selectors
  task automatic issue(gsr_pkg::gsr_mode_t m, logic v, logic w,
      gsr_pkg::gsr_opsize_t z, logic x, logic [3:0] a, logic [3:0] b,
      logic [63:0] d);
    mode = m;
    size = z;
    register_extension_prefix = x;
    valid = v;
    wr_en = w;
    sel_a = a;
    sel_b = b;
    wr_sel = b;
    wr_data = d;
  endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench: shadow registers, expectation queue, monitor.
// Assumes all stimulus changes at falling edges of the core clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {int k; logic [63:0] v;} gsr_exp_t;
  localparam gsr_pkg::gsr_mode_t RM = gsr_pkg::MODE_REAL;
  localparam gsr_pkg::gsr_mode_t LY = gsr_pkg::MODE_LEGACY;
  localparam gsr_pkg::gsr_mode_t CP = gsr_pkg::MODE_COMPAT;
  localparam gsr_pkg::gsr_mode_t LG = gsr_pkg::MODE_LONG;
  localparam gsr_pkg::gsr_opsize_t B = gsr_pkg::OPS_BYTE;
  localparam gsr_pkg::gsr_opsize_t W = gsr_pkg::OPS_WORD;
  localparam gsr_pkg::gsr_opsize_t D = gsr_pkg::OPS_DWORD;
  localparam gsr_pkg::gsr_opsize_t Q = gsr_pkg::OPS_QUAD;
  localparam gsr_pkg::gsr_opsize_t DF = gsr_pkg::OPS_DEFAULT;
  localparam logic [2:0] CODE_I = gsr_pkg::SEG_CODE;
  localparam logic [2:0] STK_I = gsr_pkg::SEG_STACK;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  gsr_pkg::gsr_mode_t mode_in;
  gsr_pkg::gsr_opsize_t op_size;
  logic acc_valid, register_extension_prefix, wr_en, fault, vdisc, ld_rej, lim_fault;
  logic seg_ld, seg_exp, a_valid, a_stk;
  logic [3:0] rd_a_sel, rd_b_sel, wr_sel;
  logic [63:0] wr_data, rd_a, rd_b, seg_base, ip, a_off, a_lin, f_lin, gv;
  logic [2:0] seg_idx, seg_rd, a_seg;
  logic [15:0] seg_sel, seg_rd_sel, f_sel;
  logic [31:0] seg_lim;
  logic [63:0] sh [16];
  logic [15:0] ss [6];
  logic [63:0] sb [6];
  logic [31:0] sl [6];
  gsr_pkg::gsr_mode_t pv;
  gsr_exp_t q [$];
  gsr_exp_t ex;
  int err_count = 0;
  int cmp_count = 0;
  int unsigned seed;
  string nm [10] = '{"rd_a", "rd_b", "fault", "discard", "reject",
    "seg_sel", "linear", "lim_fault", "fetch", "fetch_sel"};

  ////////////////////////////////////////////////////////////////////////
  // Clock, design and partner
  always #10 core_clk = ~core_clk;
  gsr_regfile u_dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
    .MODE_IN(mode_in), .ACC_VALID(acc_valid), .OP_SIZE(op_size),
    .REGISTER_EXTENSION_PREFIX(register_extension_prefix), .RD_A_SEL(rd_a_sel),
    .RD_B_SEL(rd_b_sel), .GPR_WR_EN(wr_en), .GPR_WR_SEL(wr_sel),
    .GPR_WR_DATA(wr_data), .RD_A_DATA(rd_a), .RD_B_DATA(rd_b),
    .ACCESS_FAULT(fault), .UPPER_VECTOR_DISCARD(vdisc),
    .SEG_LD_EN(seg_ld), .SEG_LD_IDX(seg_idx), .SEG_LD_EXPLICIT(seg_exp),
    .SEG_LD_SELECTOR(seg_sel), .SEG_LD_BASE(seg_base),
    .SEG_LD_LIMIT(seg_lim), .SEG_LD_REJECT(ld_rej), .SEG_RD_IDX(seg_rd),
    .SEG_RD_SELECTOR(seg_rd_sel), .INSTRUCTION_OFFSET_POINTER(ip),
    .FETCH_SELECTOR(f_sel), .FETCH_LINEAR(f_lin), .ADDR_VALID(a_valid),
    .ADDR_STACK(a_stk), .ADDR_SEG(a_seg), .ADDR_OFFSET(a_off),
    .ADDR_LINEAR(a_lin), .ADDR_LIMIT_FAULT(lim_fault));
  gsr_decode_model u_dec (.mode(mode_in), .valid(acc_valid),
    .size(op_size), .register_extension_prefix(register_extension_prefix), .sel_a(rd_a_sel), .sel_b(rd_b_sel),
    .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data));

  ////////////////////////////////////////////////////////////////////////
  // Register location {high byte, index} and read view
  function automatic logic [4:0] loc(logic [3:0] s, gsr_pkg::gsr_opsize_t z,
      logic x, gsr_pkg::gsr_mode_t m);
    if (z == B && !(x && m == LG) && s[3:2] == 2'b01) return {3'h4, s[1:0]};
    return {1'b0, s};
  endfunction
  function automatic logic [63:0] view(logic [3:0] s,
      gsr_pkg::gsr_opsize_t z, logic x, gsr_pkg::gsr_mode_t m);
    logic [4:0] l;
    logic [63:0] r;
    l = loc(s, z, x, m);
    r = sh[l[3:0]];
    case (z)
      B: return {56'h0, l[4] ? r[15:8] : r[7:0]};
      W: return {48'h0, r[15:0]};
      Q: return r;
      default: return {32'h0, r[31:0]};
    endcase
  endfunction
  function automatic logic [63:0] got(int k);
    case (k)
      0: return rd_a;
      1: return rd_b;
      2: return {63'h0, fault};
      3: return {63'h0, vdisc};
      4: return {63'h0, ld_rej};
      5: return {48'h0, seg_rd_sel};
      6: return a_lin;
      7: return {63'h0, lim_fault};
      8: return f_lin;
      default: return {48'h0, f_sel};
    endcase
  endfunction
  function automatic logic [63:0] rnd();
    return {$urandom, $urandom};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks, expectation queue and closing report
  task automatic cmp_val(string n, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_flag(string n, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic push(int k, logic [63:0] v);
    q.push_back('{k, v});
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One cycle: drive, note expected results (reads only when no fault), advance the shadow
  task automatic step(gsr_pkg::gsr_mode_t m, logic v, logic w,
      gsr_pkg::gsr_opsize_t z, logic x, logic [3:0] ra, logic [3:0] ws,
      logic [63:0] d);
    logic lg, f, rj;
    logic [4:0] l;
    logic [2:0] e;
    logic [63:0] o;
    u_dec.issue(m, v, w, z, x, ra, ws, d);
    lg = (m == LG);
    f = v && !(x && lg) && (z == Q || ws[3] || ra[3]);
    rj = seg_ld && (seg_idx > 5 || (seg_idx == CODE_I && seg_exp) ||
      ((seg_idx == CODE_I || seg_idx == STK_I) && seg_sel[15:3] == 0));
    e = a_stk ? STK_I : a_seg;
    o = (e > 5 || (lg && e < 4)) ? 64'h0 : sb[e];
    if (!f) push(0, view(ra, z, x, m));
    if (!f) push(1, view(ws, z, x, m));
    push(2, f);
    push(3, (m == RM || m == LY) && (pv == CP || pv == LG));
    push(4, rj);
    push(5, seg_rd < 6 ? ss[seg_rd] : 16'h0);
    push(6, o + a_off);
    push(7, !lg && a_valid &&
      a_off[31:0] > (e > 5 ? 32'hFFFF_FFFF : sl[e]));
    push(8, (lg ? 64'h0 : sb[CODE_I]) + ip);
    push(9, {48'h0, ss[CODE_I]});
    if (rj == 1'b0 && seg_ld) begin
      ss[seg_idx] = seg_sel;
      sb[seg_idx] = seg_base;
      sl[seg_idx] = seg_lim;
    end
    if (pv == LG && !lg) for (int i = 0; i < 8; i++) sh[i][63:32] = 32'h0;
    if ((m == RM || m == LY) && (pv == CP || pv == LG))
      for (int i = 8; i < 16; i++) sh[i] = 64'h0;
    l = loc(ws, z, x, m);
    if (v && w && !f) case (z)
      Q: sh[l[3:0]] = d;
      W: sh[l[3:0]][15:0] = d[15:0];
      B: if (l[4]) sh[l[3:0]][15:8] = d[7:0]; else sh[l[3:0]][7:0] = d[7:0];
      default: sh[l[3:0]] = {32'h0, d[31:0]};
    endcase
    pv = m;
    @(negedge core_clk);
  endtask
  task automatic dump();
    for (int k = 0; k < 16; k++) step(LG, 0, 0, Q, 1, 4'(k), 4'(15 - k), 0);
  endtask
  task automatic segld(logic [2:0] i, logic e, logic [15:0] s,
      gsr_pkg::gsr_mode_t m);
    seg_ld = 1'b1;
    seg_idx = i;
    seg_exp = e;
    seg_sel = s;
    seg_base = rnd();
    seg_lim = $urandom;
    seg_rd = i - 3'h1;
    step(m, 0, 0, D, 0, 4'h0, 4'h1, 64'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitor: takes the oldest notes as each cycle's results settle
  always @(posedge core_clk) begin
    #1;
    while (q.size() > 0) begin
      ex = q.pop_front();
      gv = got(ex.k);
      if (ex.k inside {2, 3, 4, 7}) cmp_flag(nm[ex.k], ex.v[0], gv[0]);
      else cmp_val(nm[ex.k], ex.v, gv);
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    test_done;
  end

  // Main sequence
  initial begin
    {seg_ld, seg_exp, a_valid, a_stk, seg_idx, seg_rd, a_seg} = '0;
    {seg_sel, seg_base, seg_lim, ip, a_off} = '0;
    for (int i = 0; i < 16; i++) sh[i] = 64'h0;
    for (int i = 0; i < 6; i++)
      {ss[i], sb[i], sl[i]} = {80'h0, 32'hFFFF_FFFF};
    pv = RM;
    seed = $urandom(83888);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    step(RM, 0, 0, DF, 0, 4'h0, 4'h1, 64'h0);
    for (int i = 0; i < 16; i++) begin
      step(LG, 1, 1, Q, 1, 4'(i + 15), 4'(i), rnd());
    end
    for (int z = 0; z < 5; z++) begin
      for (int k = 0; k < 32; k++) begin
        step(LG, 0, 0, gsr_pkg::gsr_opsize_t'(z), k[4], 4'(k), 4'(k + 1),
          0);
      end
    end
    step(LG, 1, 1, DF, 0, 4'h2, 4'h2, rnd());
    step(LG, 1, 1, D, 1, 4'h9, 4'h9, rnd());
    step(LG, 1, 1, W, 0, 4'h3, 4'h3, rnd());
    step(LG, 1, 1, B, 0, 4'h5, 4'h5, rnd());
    step(LG, 1, 1, B, 1, 4'h5, 4'h5, rnd());
    step(LG, 1, 1, B, 1, 4'h0, 4'hC, rnd());
    step(LG, 1, 1, Q, 0, 4'h1, 4'h1, rnd());
    step(LG, 1, 1, D, 0, 4'h9, 4'h9, rnd());
    dump();
    step(CP, 1, 1, Q, 1, 4'h1, 4'h1, rnd());
    step(CP, 1, 1, D, 0, 4'h3, 4'h3, rnd());
    dump();
    step(CP, 0, 0, D, 0, 4'h0, 4'h8, 0);
    step(LY, 0, 0, D, 0, 4'h0, 4'h8, 0);
    step(RM, 0, 0, D, 0, 4'h0, 4'h8, 0);
    step(CP, 0, 0, D, 0, 4'h0, 4'h8, 0);
    dump();
    for (int e = 0; e < 2; e++) begin
      for (int i = 0; i < 8; i++) begin
        segld(3'(i), e[0], 16'($urandom), LY);
      end
    end
    segld(STK_I, 1, 16'h0003, LY);
    segld(STK_I, 1, 16'h0008, LG);
    segld(CODE_I, 0, 16'h0002, LG);
    seg_ld = 1'b0;
    for (int k = 0; k < 32; k++) begin
      a_seg = 3'(k);
      a_stk = k[3];
      a_valid = (k % 5 != 0);
      a_off = rnd();
      ip = rnd();
      seg_rd = 3'(k);
      step(k[4] ? LG : LY, 0, 0, D, 0, 4'h0, 4'h1, 0);
    end
    repeat (2) @(negedge core_clk);
    test_done;
  end
endmodule
`default_nettype wire
